// ---- pkg/seip_pkg.sv ----
// Overview of operation
// - enabled event gives one low irq pulse
// - init-phase pulse settings apply to pulses
// - masked sources never produce a pulse
// - each gpio level change raises event
// - per-gpio wake event when wake enabled
// - CAN wake-up raises an event
// - LIN wake-up raises an event
// - CAN stuck, dominant and overtemp faults flagged
// - LIN stuck, dominant and overtemp faults flagged
// - software interrupt request gives a pulse
// - clock count not sixteen flags framing error in main state
// - bad access, init write outside init phase, bad address flagged in main state
// - parity mismatch raises an event in main state
// - secured check failure raises an event
// - aux/sensor current limit timeout raises event
// - CAN supply thermal shutdown raises event
// - buck/boost mode reported as event source
// - sensor reference thermal shutdown raises event
package seip_pkg;
   // -------------------------------------------------------
   // event source layout
   // -------------------------------------------------------
   localparam int unsigned NUM_GPIO = 6;
   localparam int unsigned NUM_SRC = 32;
   localparam int unsigned SRC_GPIO_CHG = 0;
   localparam int unsigned SRC_GPIO_WAKE = 6;
   localparam int unsigned SRC_CAN_WAKE = 12;
   localparam int unsigned SRC_LIN_WAKE = 13;
   localparam int unsigned SRC_CAN_RX_REC = 14;
   localparam int unsigned SRC_CAN_TX_DOM = 15;
   localparam int unsigned SRC_CAN_BUS_DOM = 16;
   localparam int unsigned SRC_CAN_OVER_TEMP = 17;
   localparam int unsigned SRC_LIN_RX_REC = 18;
   localparam int unsigned SRC_LIN_TX_DOM = 19;
   localparam int unsigned SRC_LIN_BUS_DOM = 20;
   localparam int unsigned SRC_LIN_OVER_TEMP = 21;
   localparam int unsigned SRC_SPI_CLK = 22;
   localparam int unsigned SRC_SPI_REQ = 23;
   localparam int unsigned SRC_SPI_PAR = 24;
   localparam int unsigned SRC_SPI_SEC = 25;
   localparam int unsigned SRC_AUX_ILIM = 26;
   localparam int unsigned SRC_SNS_ILIM = 27;
   localparam int unsigned SRC_CAN_TSD = 28;
   localparam int unsigned SRC_BOB = 29;
   localparam int unsigned SRC_SNS_TSD = 30;
   localparam int unsigned SRC_SW_REQ = 31;
   // -------------------------------------------------------
   // serial frame and pulse timing
   // -------------------------------------------------------
   localparam logic [4:0] FRAME_CLKS = 5'h10;
   localparam int unsigned PW_BITS = 8;
   localparam logic [PW_BITS-1:0] PW_RESET = 8'h64;
   localparam logic [PW_BITS-1:0] PW_MIN = 8'h01;
   localparam logic [NUM_SRC-1:0] MASK_RESET = 32'h00000000;
   typedef logic [NUM_SRC-1:0] seip_src_t;
   typedef enum logic [1:0]
   {
      SEIP_IDLE = 2'b00,
      SEIP_PULSE = 2'b01,
      SEIP_GAP = 2'b10
   } seip_state_e;
endpackage : seip_pkg

// ---- pkg/seip_pulse_if.sv ----
`timescale 1ns/1ps
interface seip_pulse_if;
   import seip_pkg::*;
   logic trigger;
   logic [PW_BITS-1:0] width;
   logic gapEn;
   logic busy;
   logic irqLow;
   modport ctrl (output trigger, output width, output gapEn, input busy, input irqLow);
   modport gen (input trigger, input width, input gapEn, output busy, output irqLow);
endinterface : seip_pulse_if

// ---- core/seip_pulse_gen.sv ----
`timescale 1ns/1ps
module seip_pulse_gen
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // pulse control
   seip_pulse_if.gen pif
);
   import seip_pkg::*;
   seip_state_e state_q;
   seip_state_e state_d;
   logic [PW_BITS-1:0] cnt_q;
   logic [PW_BITS-1:0] cnt_d;
   logic irq_q;
   logic lastCnt;
   assign lastCnt = (cnt_q <= PW_MIN);
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         SEIP_IDLE:
         begin
            if (pif.trigger)
            begin
               state_d = SEIP_PULSE;
               cnt_d = (pif.width < PW_MIN) ? PW_MIN : pif.width;
            end
         end
         SEIP_PULSE:
         begin
            cnt_d = cnt_q - PW_MIN;
            if (lastCnt)
            begin
               state_d = pif.gapEn ? SEIP_GAP : SEIP_IDLE;
               cnt_d = (pif.width < PW_MIN) ? PW_MIN : pif.width;
            end
         end
         SEIP_GAP:
         begin
            cnt_d = cnt_q - PW_MIN;
            if (lastCnt)
               state_d = SEIP_IDLE;
         end
         default:
         begin
            state_d = SEIP_IDLE;
         end
      endcase
   end
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= SEIP_IDLE;
         cnt_q <= '0;
         irq_q <= 1'b0;
      end
      else if (clkEn)
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         irq_q <= (state_d == SEIP_PULSE);
      end
   end
   assign pif.busy = (state_q != SEIP_IDLE);
   assign pif.irqLow = irq_q;
endmodule : seip_pulse_gen

// ---- core/seip_event_irq.sv ----
`timescale 1ns/1ps
module seip_event_irq
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // configuration
   input wire logic initPhase,
   input wire logic cfgWrite,
   input wire logic [seip_pkg::PW_BITS-1:0] cfgPulseWidth,
   input wire logic cfgGapEn,
   input wire seip_pkg::seip_src_t cfgMask,
   input wire logic [seip_pkg::NUM_GPIO-1:0] gpioWakeEn,
   input wire logic swIrqReq,
   // gpio and transceivers
   input wire logic [seip_pkg::NUM_GPIO-1:0] gpioLevel,
   input wire logic [seip_pkg::NUM_GPIO-1:0] gpioWakeDet,
   input wire logic can_wake_event,
   input wire logic lin_wake_event,
   input wire logic canRxStuckRecessive,
   input wire logic canTxStuckDominant,
   input wire logic canBusDominant,
   input wire logic can_over_temp,
   input wire logic lin_rx_stuck_recessive,
   input wire logic lin_tx_stuck_dominant,
   input wire logic linBusDominant,
   input wire logic lin_over_temp,
   // serial frame checks
   input wire logic chip_select_n,
   input wire logic spiClkEdge,
   input wire logic mainState,
   input wire logic frameDone,
   input wire logic frameParityOk,
   input wire logic frameSecureOk,
   input wire logic frameMalformed,
   input wire logic frameInitWrite,
   input wire logic frameBadAddr,
   // supplies
   input wire logic auxIlimExpired,
   input wire logic snsIlimExpired,
   input wire logic canSupplyTsd,
   input wire logic boostMode,
   input wire logic snsRefTsd,
   // outputs
   output logic irq_out_n,
   output logic canSupplyEnable,
   output seip_pkg::seip_src_t eventStatus
);
   import seip_pkg::*;
   // -------------------------------------------------------
   // configuration latched in init phase
   // -------------------------------------------------------
   logic [PW_BITS-1:0] pw_q;
   logic gap_q;
   seip_src_t mask_q;
   logic cfgTake;
   assign cfgTake = cfgWrite && initPhase;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pw_q <= PW_RESET;
         gap_q <= 1'b0;
         mask_q <= MASK_RESET;
      end
      else if (clkEn && cfgTake)
      begin
         pw_q <= cfgPulseWidth;
         gap_q <= cfgGapEn;
         mask_q <= cfgMask;
      end
   end
   // -------------------------------------------------------
   // frame clock counter
   // -------------------------------------------------------
   logic [4:0] clkCnt_q;
   logic csLow_q;
   logic frameEnd;
   logic clkCntBad;
   logic frameCheck;
   assign frameEnd = csLow_q && chip_select_n;
   assign clkCntBad = frameEnd && mainState && (clkCnt_q != FRAME_CLKS);
   assign frameCheck = frameDone && mainState;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         clkCnt_q <= '0;
         csLow_q <= 1'b0;
      end
      else if (clkEn)
      begin
         csLow_q <= !chip_select_n;
         if (chip_select_n)
            clkCnt_q <= '0;
         else if (spiClkEdge && clkCnt_q != '1)
            clkCnt_q <= clkCnt_q + 5'h01;
      end
   end
   // -------------------------------------------------------
   // raw source levels
   // -------------------------------------------------------
   seip_src_t srcLvl;
   logic bobPrev_q;
   logic [NUM_GPIO-1:0] gpioPrev_q;
   logic [NUM_GPIO-1:0] gpioChg;
   assign gpioChg = gpioLevel ^ gpioPrev_q;
   assign srcLvl[SRC_GPIO_CHG +: NUM_GPIO] = gpioChg;
   assign srcLvl[SRC_GPIO_WAKE +: NUM_GPIO] = gpioWakeDet & gpioWakeEn;
   assign srcLvl[SRC_CAN_WAKE] = can_wake_event;
   assign srcLvl[SRC_LIN_WAKE] = lin_wake_event;
   assign srcLvl[SRC_CAN_RX_REC] = canRxStuckRecessive;
   assign srcLvl[SRC_CAN_TX_DOM] = canTxStuckDominant;
   assign srcLvl[SRC_CAN_BUS_DOM] = canBusDominant;
   assign srcLvl[SRC_CAN_OVER_TEMP] = can_over_temp;
   assign srcLvl[SRC_LIN_RX_REC] = lin_rx_stuck_recessive;
   assign srcLvl[SRC_LIN_TX_DOM] = lin_tx_stuck_dominant;
   assign srcLvl[SRC_LIN_BUS_DOM] = linBusDominant;
   assign srcLvl[SRC_LIN_OVER_TEMP] = lin_over_temp;
   assign srcLvl[SRC_SPI_CLK] = clkCntBad;
   assign srcLvl[SRC_SPI_REQ] = frameCheck && (frameMalformed || (frameInitWrite && !initPhase) || frameBadAddr);
   assign srcLvl[SRC_SPI_PAR] = frameCheck && !frameParityOk;
   assign srcLvl[SRC_SPI_SEC] = frameDone && !frameSecureOk;
   assign srcLvl[SRC_AUX_ILIM] = auxIlimExpired;
   assign srcLvl[SRC_SNS_ILIM] = snsIlimExpired;
   assign srcLvl[SRC_CAN_TSD] = canSupplyTsd;
   assign srcLvl[SRC_SNS_TSD] = snsRefTsd;
   assign srcLvl[SRC_SW_REQ] = swIrqReq;
   // mode change in either direction is the event
   assign srcLvl[SRC_BOB] = boostMode ^ bobPrev_q;
   // -------------------------------------------------------
   // edge detection and pending
   // -------------------------------------------------------
   seip_src_t lvl_q;
   seip_src_t rise;
   seip_src_t pend_q;
   seip_src_t pend_d;
   logic pulseStart;
   seip_pulse_if pif();
   assign rise = srcLvl & ~lvl_q;
   assign pulseStart = (|pend_q) && !pif.busy;
   // a new edge in the start cycle stays pending
   assign pend_d = (pulseStart ? '0 : pend_q) | (rise & ~mask_q);
   assign canSupplyEnable = !canSupplyTsd;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lvl_q <= '0;
         pend_q <= '0;
         gpioPrev_q <= '0;
         bobPrev_q <= 1'b0;
         eventStatus <= '0;
      end
      else if (clkEn)
      begin
         lvl_q <= srcLvl;
         pend_q <= pend_d;
         gpioPrev_q <= gpioLevel;
         bobPrev_q <= boostMode;
         eventStatus <= eventStatus | rise;
         if (pulseStart)
            eventStatus <= rise;
      end
   end
   // -------------------------------------------------------
   // pulse generation
   // -------------------------------------------------------
   assign pif.trigger = pulseStart;
   assign pif.width = pw_q;
   assign pif.gapEn = gap_q;
   seip_pulse_gen u_pulse
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .pif(pif)
   );
   assign irq_out_n = !pif.irqLow;
   // -------------------------------------------------------
   // checks
   // -------------------------------------------------------
   a_masked_no_pend: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clkEn && !pulseStart && pend_q == '0 && (rise & ~mask_q) == '0) |=> pend_q == '0)
      else $error("masked event became pending");
   a_pend_fires: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clkEn && pulseStart) |=> !clkEn || !irq_out_n)
      else $error("pending event gave no pulse");
   a_pulse_returns: assert property (@(posedge sys_clk) disable iff (!nrst)
      $fell(irq_out_n) |-> ##[1:300] irq_out_n)
      else $error("interrupt output stuck low");
   a_sw_request: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clkEn && rise[SRC_SW_REQ] && !mask_q[SRC_SW_REQ]) |=> pend_q[SRC_SW_REQ] || !irq_out_n)
      else $error("software request lost");
   a_frame_count: assert property (@(posedge sys_clk) disable iff (!nrst)
      (frameEnd && mainState && clkCnt_q == FRAME_CLKS) |-> !srcLvl[SRC_SPI_CLK])
      else $error("good frame flagged as framing error");
   a_cfg_locked: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clkEn && !initPhase) |=> $stable(pw_q))
      else $error("pulse width changed outside init");
   a_gpio_change: assert property (@(posedge sys_clk) disable iff (!nrst)
      (clkEn ##1 clkEn && gpioLevel != $past(gpioLevel)) |-> srcLvl[SRC_GPIO_CHG +: NUM_GPIO] != '0)
      else $error("gpio change not seen");
   a_can_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
      $fell(canSupplyTsd) |-> canSupplyEnable)
      else $error("can supply not restarted");
endmodule : seip_event_irq

// ---- testbench/seip_host_model.sv ----
`timescale 1ns/1ps
module seip_host_model
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // interrupt input of the host
   input wire logic irq_out_n,
   // observed pulses
   output int pulses,
   output int lastWidth
);
   int run;
   // counts low pulses and measures each low time in cycles
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pulses <= 0;
         lastWidth <= 0;
         run <= 0;
      end
      else if (!irq_out_n)
         run <= run + 1;
      else if (run != 0)
      begin
         pulses <= pulses + 1;
         lastWidth <= run;
         run <= 0;
      end
   end
endmodule : seip_host_model

// ---- testbench/seip_event_irq_tb.sv ----
`timescale 1ns/1ps
module seip_event_irq_tb;
   import seip_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic clkEn = 1'b1;
   logic initPhase = 1'b1;
   logic cfgWrite = 1'b0;
   logic [PW_BITS-1:0] cfgPulseWidth = 8'h04;
   logic cfgGapEn = 1'b0;
   seip_src_t cfgMask = 32'h00000000;
   logic [NUM_GPIO-1:0] gpioWakeEn = 6'h00;
   logic chip_select_n = 1'b1;
   logic spiClkEdge = 1'b0;
   logic mainState = 1'b1;
   logic frameDone = 1'b0;
   logic [4:0] frameFlags = 5'h18;
   seip_src_t src = 32'h00000000;
   logic frameParityOk, frameSecureOk, frameMalformed, frameInitWrite, frameBadAddr;
   logic swIrqReq, snsRefTsd, boostMode, canSupplyTsd, snsIlimExpired, auxIlimExpired;
   logic lin_over_temp, linBusDominant, lin_tx_stuck_dominant, lin_rx_stuck_recessive, can_over_temp;
   logic canBusDominant, canTxStuckDominant, canRxStuckRecessive, lin_wake_event, can_wake_event;
   logic [NUM_GPIO-1:0] gpioWakeDet, gpioLevel;
   logic irq_out_n, canSupplyEnable;
   seip_src_t eventStatus;
   int pulses, lastWidth, mismatches = 0, cmpCount = 0, cycles = 0, expW = 4;
   assign {swIrqReq, snsRefTsd, boostMode, canSupplyTsd, snsIlimExpired, auxIlimExpired} = src[31:26];
   assign {lin_over_temp, linBusDominant, lin_tx_stuck_dominant, lin_rx_stuck_recessive, can_over_temp,
      canBusDominant, canTxStuckDominant, canRxStuckRecessive, lin_wake_event, can_wake_event,
      gpioWakeDet, gpioLevel} = src[21:0];
   assign {frameParityOk, frameSecureOk, frameMalformed, frameInitWrite, frameBadAddr} = frameFlags;
   seip_event_irq dut (.*);
   seip_host_model host (.sys_clk(sys_clk), .nrst(nrst), .irq_out_n(irq_out_n), .pulses(pulses),
      .lastWidth(lastWidth));
   always #5 sys_clk = ~sys_clk;
   // -------------------------------------------------------
   // checking and closing
   // -------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmpCount++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
      if (mismatches == 0 && cmpCount > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         print_verdict();
      end
   end
   // -------------------------------------------------------
   // scenarios
   // -------------------------------------------------------
   // one configuration write; only honoured in the init phase
   task automatic cfg(input logic [7:0] w, input seip_src_t m, input logic ph);
      initPhase <= ph;
      cfgPulseWidth <= w;
      cfgMask <= m;
      cfgWrite <= 1'b1;
      @(posedge sys_clk);
      cfgWrite <= 1'b0;
      @(posedge sys_clk);
   endtask : cfg
   // toggles one source and counts pulses while the new level is held
   task automatic fire(input int i, input int n);
      int p0;
      p0 = pulses;
      src[i] <= ~src[i];
      repeat (24) @(posedge sys_clk);
      check(32'(pulses - p0), 32'(n), "pulse count");
      if (n > 0)
         check(32'(lastWidth), 32'(expW), "pulse width");
   endtask : fire
   // one serial frame with a given clock count and frame flags
   task automatic frame(input int clks, input logic [4:0] fl, input int n);
      int p0;
      p0 = pulses;
      chip_select_n <= 1'b0;
      repeat (clks)
      begin
         @(posedge sys_clk);
         spiClkEdge <= 1'b1;
         @(posedge sys_clk);
         spiClkEdge <= 1'b0;
      end
      @(posedge sys_clk);
      frameFlags <= fl;
      frameDone <= 1'b1;
      @(posedge sys_clk);
      frameDone <= 1'b0;
      frameFlags <= 5'h18;
      chip_select_n <= 1'b1;
      repeat (24) @(posedge sys_clk);
      check(32'(pulses - p0), 32'(n), "frame pulses");
   endtask : frame
   initial
   begin
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      check(32'(irq_out_n), 32'h1, "idle level");
      check(eventStatus, 32'h0, "status after reset");
      cfg(8'h04, 32'h00001000, 1'b1);
      fire(12, 0);
      check(eventStatus, 32'h00001000, "masked source status");
      fire(12, 0);
      cfg(8'h06, 32'h0, 1'b0);
      fire(31, 1);
      check(eventStatus, 32'h0, "status cleared on pulse start");
      fire(31, 0);
      cfg(8'h03, 32'h0, 1'b1);
      expW = 3;
      fire(13, 1);
      fire(13, 0);
      fire(6, 0);
      fire(6, 0);
      gpioWakeEn <= 6'h3f;
      for (int i = 0; i < 32; i++)
      begin
         if (i < 22 || i > 25)
         begin
            fire(i, 1);
            if (i == 28)
               check(32'(canSupplyEnable), 32'h0, "supply off");
            fire(i, (i < 6 || i == 29) ? 1 : 0);
            check(32'(canSupplyEnable), 32'h1, "supply restart");
         end
      end
      frame(16, 5'h18, 0);
      frame(15, 5'h18, 1);
      frame(17, 5'h18, 1);
      frame(16, 5'h08, 1);
      frame(16, 5'h10, 1);
      frame(16, 5'h1c, 1);
      frame(16, 5'h1a, 0);
      initPhase <= 1'b0;
      frame(16, 5'h1a, 1);
      mainState <= 1'b0;
      frame(15, 5'h08, 0);
      mainState <= 1'b1;
      frame(16, 5'h19, 1);
      print_verdict();
   end
endmodule : seip_event_irq_tb
